// File: tb/cac_far_model.sv
`timescale 1ns/1ps
module cac_far_model
(
  input wire logic clk_i,   // System clock.
  output logic sclk_o = 1'b0,  // Serial clock, still between frames.
  output logic sdin_o = 1'b0,  // Serial data.
  output logic cs_n_o = 1'b1,  // Serial select, active low.
  output logic conv_o,         // Converter clock, free running.
  output logic reset_level_sample_n_o,  // Reset-level sample pulse, active low.
  output logic video_level_sample_n_o,  // Video-level sample pulse, active low.
  output logic clamp_n_o,               // Input clamp pulse, active low.
  output logic trig_n_o = 1'b1 // Calibration trigger, active low.
);
  logic [2:0] ph_r = 3'h0;
  logic [5:0] pix_r = 6'h00;

  // The converter clock runs free at one eighth of the system clock.
  always @(negedge clk_i)
    ph_r <= ph_r + 3'h1;
  assign conv_o = ph_r[2];

  // One converter period is one pixel, and a line is 64 pixels.
  always @(negedge clk_i)
    if (ph_r == 3'h7)
      pix_r <= pix_r + 6'h01;
  // Reset level first, then video, both before the converter clock goes high.
  assign reset_level_sample_n_o = (ph_r != 3'h0);
  assign video_level_sample_n_o = (ph_r != 3'h2);
  // The first pixel of a line stands in for the dummy pixels that the clamp needs.
  assign clamp_n_o = !(pix_r == 6'h00 && ph_r == 3'h1);

  ////////////////////////////////////////////////////////////////////////
  // Called at a falling edge; each serial clock phase lasts two cycles.
  task automatic send(input logic [15:0] w, input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      cs_n_o <= 1'b0;
      sclk_o <= 1'b0;
      sdin_o <= w[15 - i];
      repeat (2) @(negedge clk_i);
      sclk_o <= 1'b1;
      repeat (2) @(negedge clk_i);
    end
    sclk_o <= 1'b0;
    @(negedge clk_i);
    cs_n_o <= 1'b1;
    // A released data line must not keep showing the last bit.
    sdin_o <= ~sdin_o;
  endtask

  // Goes low just after a converter fall; a long pulse spans a high phase.
  task automatic pulse(input int len);
    int i;
    for (i = 0; i < 8 && ph_r != 3'h7; i++)
      @(negedge clk_i);
    @(negedge clk_i);
    trig_n_o <= 1'b0;
    repeat (len) @(negedge clk_i);
    trig_n_o <= 1'b1;
  endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cac_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic oe_n = 1'b0;
  logic [9:0] smp = 10'h000;
  logic [9:0] avg = 10'h2b4;
  logic [9:0] ofs = 10'h15c;
  logic sclk, sdin, cs_n, conv, trig_n;
  logic [9:0] dout, doen;
  logic [8:0] line, gain;
  logic [7:0] pix, dac1, dac2;
  logic [3:0] bias;
  logic [1:0] tsrc;
  logic cal, toen, ext, refpd, coarse, sb1, sb2;
  logic sr_n, sv_n, clamp_n;
  int n_mismatch = 0;
  int compares = 0;
  int n_cal = 0;
  int n_sr = 0;
  int n_sv = 0;
  int n_clamp = 0;

  cac_far_model u_far (.clk_i(clk), .sclk_o(sclk), .sdin_o(sdin), .cs_n_o(cs_n), .conv_o(conv),
    .reset_level_sample_n_o(sr_n), .video_level_sample_n_o(sv_n), .clamp_n_o(clamp_n),
    .trig_n_o(trig_n));

  cac_config_top uut (.CLK_I(clk), .RSTN_I(rst_n), .SCLK_I(sclk), .SDIN_I(sdin), .CS_N_I(cs_n),
    .CONVERTER_CLOCK_I(conv), .BLACK_CAL_TRIGGER_N_I(trig_n), .OUTPUT_ENABLE_N_I(oe_n),
    .ADC_SAMPLE_I(smp), .BLACK_AVG_I(avg), .OFFSET_CODE_I(ofs), .DATA_O(dout), .DATA_OEN_O(doen),
    .LINE_COUNT_O(line), .PIXEL_COUNT_O(pix), .CAL_START_O(cal), .BIAS_CURRENT_CODE_O(bias),
    .TEST_PIN_SRC_O(tsrc), .TEST_PIN_OEN_O(toen), .EXTERNAL_REFERENCE_O(ext),
    .INTERNAL_REF_PD_O(refpd), .OFFSET_PROBE_COARSE_O(coarse), .GAIN_CODE_O(gain),
    .USER_DAC1_O(dac1), .USER_DAC2_O(dac2), .USER_DAC1_STANDBY_O(sb1), .USER_DAC2_STANDBY_O(sb2));

  always #12.5 clk = ~clk;
  // A new sample is offered after each video-level pulse, so each converter rise takes a distinct value.
  always @(negedge clk)
    if (sv_n === 1'b0)
      smp <= smp + 10'h001;
  always @(negedge clk)
  begin
    if (sr_n === 1'b0)
      n_sr <= n_sr + 1;
    if (sv_n === 1'b0)
      n_sv <= n_sv + 1;
    if (clamp_n === 1'b0)
      n_clamp <= n_clamp + 1;
  end
  always @(negedge clk)
    if (cal === 1'b1)
      n_cal <= n_cal + 1;

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [9:0] d);
    u_far.send({2'b00, a, d}, 16);
    repeat (4) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(line, 10'h001, "line_count");
    chk(pix, 10'h008, "pixel_count");
    chk(bias, 10'h003, "bias_code");
    chk({tsrc, toen, ext, refpd, coarse}, 10'h008, "test_fields");
    chk(gain, 10'h000, "gain");
    chk({dac1, sb1, sb2}, 10'h000, "dac1_standby");
    $display("done reset_values");
  endtask

  task automatic t_black;
    logic [9:0] d [5] = '{10'h08e, 10'h0f7, 10'h09f, 10'h008, 10'h032};
    logic [9:0] el [5] = '{10'h100, 10'h100, 10'h100, 10'h001, 10'h008};
    logic [9:0] ep [5] = '{10'h0c0, 10'h040, 10'h0c0, 10'h003, 10'h004};
    int i;
    for (i = 0; i < 5; i++)
    begin
      wr(ADDR_BLACK_CAL, d[i]);
      chk(line, el[i], "line_count");
      chk(pix, ep[i], "pixel_count");
    end
    $display("done black_cal_decode");
  endtask

  task automatic t_test;
    logic [9:0] d [3] = '{10'h16b, 10'h3f2, 10'h011};
    logic [9:0] eb [3] = '{10'h005, 10'h00f, 10'h000};
    logic [9:0] ef [3] = '{10'h017, 10'h020, 10'h008};
    int i;
    for (i = 0; i < 3; i++)
    begin
      wr(ADDR_TEST_BIAS, d[i]);
      chk(bias, eb[i], "bias_code");
      chk({tsrc, toen, ext, refpd, coarse}, ef[i], "test_fields");
    end
    $display("done test_bias_decode");
  endtask

  task automatic t_gain;
    wr(ADDR_GAIN, 10'h17f);
    chk(gain, 10'h17f, "gain_top");
    wr(ADDR_GAIN, 10'h0a5);
    chk(gain, 10'h0a5, "gain_mid");
    wr(ADDR_GAIN, 10'h1ff);
    chk(gain, 10'h17f, "gain_over");
    $display("done gain_code");
  endtask

  task automatic t_dac;
    wr(ADDR_USER_DAC1, 10'h3a5);
    wr(ADDR_USER_DAC2, 10'h05a);
    chk({dac1, 2'b00}, {8'ha5, 2'b00}, "dac1");
    chk(dac2, 10'h05a, "dac2");
    wr(ADDR_CONTROL, 10'h180);
    chk({sb1, sb2}, 10'h003, "standby_both");
    wr(ADDR_CONTROL, 10'h100);
    chk({sb1, sb2}, 10'h002, "standby_dac1");
    wr(ADDR_CONTROL, 10'h000);
    wr(ADDR_CONTROL, 10'h181);
    chk({dac1, sb1, sb2}, 10'h000, "soft_reset_dac");
    chk(gain, 10'h000, "soft_reset_gain");
    chk(line, 10'h001, "soft_reset_line");
    chk(pix, 10'h008, "soft_reset_pixel");
    chk(bias, 10'h003, "soft_reset_bias");
    $display("done user_dacs");
  endtask

  task automatic t_trunc;
    wr(ADDR_GAIN, 10'h040);
    u_far.send({2'b00, ADDR_GAIN, 10'h123}, 15);
    repeat (4) @(negedge clk);
    chk(gain, 10'h040, "gain_short_frame");
    wr(ADDR_GAIN, 10'h123);
    chk(gain, 10'h123, "gain_full_frame");
    $display("done short_frame");
  endtask

  task automatic t_oe;
    oe_n = 1'b1;
    @(negedge clk);
    chk(doen, 10'h3ff, "oen_high");
    oe_n = 1'b0;
    @(negedge clk);
    chk(doen, 10'h000, "oen_low");
    $display("done output_enable");
  endtask

  task automatic t_mux;
    logic [9:0] e [4] = '{10'h000, avg, ofs, 10'h000};
    int i, k;
    for (i = 1; i < 4; i++)
    begin
      wr(ADDR_BLACK_CAL, {i[1:0], 8'h03});
      repeat (48) @(negedge clk);
      chk(dout, e[i], "data_source");
    end
    wr(ADDR_BLACK_CAL, 10'h003);
    repeat (60) @(negedge clk);
    for (k = 0; k < 4; k++)
    begin
      for (i = 0; i < 9; i++)
      begin
        @(negedge clk);
        #1;
        if (u_far.ph_r == 3'h4)
          break;
      end
      if (i == 9)
      begin
        n_mismatch++;
        finish_test();
      end
      chk(dout, smp - 10'h005, "data_latency");
      chk(10'(n_sv - n_sr), 10'h000, "sample_pulse_pairs");
      chk(10'(n_clamp), 10'((n_sv - 1) / 64 + 1), "clamp_per_line");
    end
    @(negedge clk);
    $display("done data_path");
  endtask

  task automatic t_cal;
    int c0;
    c0 = n_cal;
    u_far.pulse(12);
    repeat (12) @(negedge clk);
    chk(10'(n_cal - c0), 10'h001, "cal_fire");
    c0 = n_cal;
    u_far.pulse(6);
    repeat (20) @(negedge clk);
    chk(10'(n_cal - c0), 10'h000, "cal_cancel");
    $display("done cal_trigger");
  endtask

  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_black();
    t_test();
    t_gain();
    t_dac();
    t_trunc();
    t_oe();
    t_mux();
    t_cal();
    finish_test();
  end
endmodule

// File: verilog/cac_config_top.sv
// Overview of operation
// - Average over 2^L lines, 1 to 256.
// - Line exponent above eight caps at 256.
// - Average 2^N pixels per line, 1 to 64.
// - Pixel exponent above six caps at 64.
// - Triple bit multiplies pixel count by three.
// - Top two bits pick output data source.
// - Black calibration register resets to 0x003.
// - Test register resets to 0x0c0.
// - Top four test bits give bias code.
// - Test pin field selects clocks, gain outputs, float.
// - Reference bit picks external or internal reference.
// - Low test bits pick offset probe source.
// - Gain code is nine bits, linear dB.
// - Gain codes valid 0 to 383.
// - Samples appear 4.5 converter cycles later.
// - Output enable high floats data outputs.
// - Two 8-bit user DACs with power-down bits.
// - Serial word: two nulls, address, ten data.
// - Low trigger starts black-level calibration.
`timescale 1ns/1ps
module cac_config_top
  import cac_pkg::*;
(
  input wire logic CLK_I,                  // 40 MHz system clock.
  input wire logic RSTN_I,                 // Asynchronous reset, active low.
  input wire logic SCLK_I,                 // Serial clock.
  input wire logic SDIN_I,                 // Serial data.
  input wire logic CS_N_I,                 // Serial select, active low.
  input wire logic CONVERTER_CLOCK_I,      // Converter clock level.
  input wire logic BLACK_CAL_TRIGGER_N_I,  // Calibration trigger, active low.
  input wire logic OUTPUT_ENABLE_N_I,      // Data output enable, active low.
  input wire logic [9:0] ADC_SAMPLE_I,     // Converted sample.
  input wire logic [9:0] BLACK_AVG_I,      // Averager result for output mux.
  input wire logic [9:0] OFFSET_CODE_I,    // Offset DAC code for output mux.
  output logic [9:0] DATA_O,               // Parallel data output.
  output logic [9:0] DATA_OEN_O,           // Data output enable, low drives.
  output logic [8:0] LINE_COUNT_O,         // Averaged lines, 1 to 256.
  output logic [7:0] PIXEL_COUNT_O,        // Averaged pixels per line, 1 to 192.
  output logic CAL_START_O,                // Calibration start pulse.
  output logic [3:0] BIAS_CURRENT_CODE_O,  // Bias current code.
  output logic [1:0] TEST_PIN_SRC_O,       // 0 float, 1 clocks, 2 gain outputs.
  output logic TEST_PIN_OEN_O,             // Test pins enable, low drives.
  output logic EXTERNAL_REFERENCE_O,       // External reference in use.
  output logic INTERNAL_REF_PD_O,          // Internal reference powered down.
  output logic OFFSET_PROBE_COARSE_O,      // Probe shows coarse offset DAC.
  output logic [8:0] GAIN_CODE_O,          // Gain code, 0 to 383.
  output logic [7:0] USER_DAC1_O,          // User DAC1 setting.
  output logic [7:0] USER_DAC2_O,          // User DAC2 setting.
  output logic USER_DAC1_STANDBY_O,        // User DAC1 in standby.
  output logic USER_DAC2_STANDBY_O         // User DAC2 in standby.
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {CAC_IDLE = 2'b01, CAC_ARMED = 2'b10} cac_trig_e;

  function automatic logic [8:0] cac_pow2(input logic [3:0] e, input logic [3:0] emax);
    logic [3:0] c;
    c = (e > emax) ? emax : e;
    return 9'(9'h001 << c);
  endfunction

  logic wr;
  logic [3:0] waddr;
  logic [9:0] wdata;
  logic [9:0] black_r, black_nxt;
  logic [9:0] test_r, test_nxt;
  logic [9:0] ctl_r, ctl_nxt;
  logic [8:0] gain_r, gain_nxt;
  logic [7:0] dac1_r, dac1_nxt;
  logic [7:0] dac2_r, dac2_nxt;
  logic soft_rst;

  cac_serial_rx u_rx (
    .clk_i(CLK_I),
    .rst_n_i(RSTN_I),
    .sclk_i(SCLK_I),
    .sdin_i(SDIN_I),
    .cs_n_i(CS_N_I),
    .wr_o(wr),
    .addr_o(waddr),
    .data_o(wdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // A write of the system-reset bit returns every register to its default.
  assign soft_rst = wr && waddr == ADDR_CONTROL && wdata[CTL_SOFT_RESET];

  always_comb
  begin
    black_nxt = black_r;
    test_nxt = test_r;
    ctl_nxt = ctl_r;
    gain_nxt = gain_r;
    dac1_nxt = dac1_r;
    dac2_nxt = dac2_r;
    if (soft_rst)
    begin
      black_nxt = BLACK_CAL_RST;
      test_nxt = TEST_BIAS_RST;
      ctl_nxt = CONTROL_RST;
      gain_nxt = GAIN_RST;
      dac1_nxt = USER_DAC_RST;
      dac2_nxt = USER_DAC_RST;
    end
    else if (wr)
    begin
      case (waddr)
        ADDR_CONTROL: ctl_nxt = wdata;
        ADDR_GAIN: gain_nxt = wdata[8:0];
        ADDR_USER_DAC1: dac1_nxt = wdata[7:0];
        ADDR_USER_DAC2: dac2_nxt = wdata[7:0];
        ADDR_BLACK_CAL: black_nxt = wdata;
        ADDR_TEST_BIAS: test_nxt = wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      black_r <= BLACK_CAL_RST;
      test_r <= TEST_BIAS_RST;
      ctl_r <= CONTROL_RST;
      gain_r <= GAIN_RST;
      dac1_r <= USER_DAC_RST;
      dac2_r <= USER_DAC_RST;
    end
    else
    begin
      black_r <= black_nxt;
      test_r <= test_nxt;
      ctl_r <= ctl_nxt;
      gain_r <= gain_nxt;
      dac1_r <= dac1_nxt;
      dac2_r <= dac2_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Averaging geometry decoded from the black calibration register.
  logic [8:0] pix_base;

  assign LINE_COUNT_O = cac_pow2(black_r[LINE_EXP_MSB:LINE_EXP_LSB], LINE_EXP_MAX);
  assign pix_base = cac_pow2({1'b0, black_r[PIX_EXP_MSB:PIX_EXP_LSB]}, {1'b0, PIX_EXP_MAX});
  assign PIXEL_COUNT_O = black_r[PIX_TRIPLE] ? 8'(pix_base * 9'd3) : pix_base[7:0];

  // Test, reference and probe controls.
  assign BIAS_CURRENT_CODE_O = test_r[BIAS_MSB:BIAS_LSB];
  assign TEST_PIN_SRC_O = test_r[TPIN_HI] ? (test_r[TPIN_LO] ? 2'd2 : 2'd1) : 2'd0;
  assign TEST_PIN_OEN_O = ~test_r[TPIN_HI];
  assign EXTERNAL_REFERENCE_O = test_r[EXT_REF];
  assign INTERNAL_REF_PD_O = test_r[EXT_REF];
  assign OFFSET_PROBE_COARSE_O = test_r[PROBE_HI] & test_r[PROBE_LO];

  // Out-of-range gain is held to the top valid code so the stage never sees it.
  assign GAIN_CODE_O = (gain_r > GAIN_MAX) ? GAIN_MAX : gain_r;
  assign USER_DAC1_O = dac1_r;
  assign USER_DAC2_O = dac2_r;
  assign USER_DAC1_STANDBY_O = ctl_r[CTL_DAC1_PD];
  assign USER_DAC2_STANDBY_O = ctl_r[CTL_DAC2_PD];

  ////////////////////////////////////////////////////////////////////////////////
  // Converter clock edges and calibration trigger.
  logic conv_r, conv_nxt;
  logic conv_rise, conv_fall;
  cac_trig_e trig_r, trig_nxt;
  logic start_r, start_nxt;

  assign conv_rise = CONVERTER_CLOCK_I && !conv_r;
  assign conv_fall = !CONVERTER_CLOCK_I && conv_r;

  // A trigger counts only if it stays low across a converter clock high phase.
  always_comb
  begin
    conv_nxt = CONVERTER_CLOCK_I;
    trig_nxt = trig_r;
    start_nxt = 1'b0;
    case (trig_r)
      CAC_IDLE:
        if (!BLACK_CAL_TRIGGER_N_I && conv_rise)
          trig_nxt = CAC_ARMED;
      CAC_ARMED:
        if (BLACK_CAL_TRIGGER_N_I)
          trig_nxt = CAC_IDLE;
        else if (conv_fall)
        begin
          start_nxt = 1'b1;
          trig_nxt = CAC_IDLE;
        end
      default: trig_nxt = CAC_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      conv_r <= 1'b0;
      trig_r <= CAC_IDLE;
      start_r <= 1'b0;
    end
    else
    begin
      conv_r <= conv_nxt;
      trig_r <= trig_nxt;
      start_r <= start_nxt;
    end
  end

  assign CAL_START_O = start_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Output source mux and delay.
  logic [9:0] sel_sample;
  logic [9:0] data_r, data_nxt;
  logic [9:0] piped;

  always_comb
  begin
    case (black_r[OSEL_HI:OSEL_LO])
      2'b00: sel_sample = ADC_SAMPLE_I;
      2'b01: sel_sample = BLACK_AVG_I;
      2'b10: sel_sample = OFFSET_CODE_I;
      default: sel_sample = 10'h000;
    endcase
  end

  cac_out_pipe u_pipe (
    .clk_i(CLK_I),
    .rst_n_i(RSTN_I),
    .conv_rise_i(conv_rise),
    .conv_fall_i(conv_fall),
    .sample_i(sel_sample),
    .data_o(piped)
  );

  always_comb
  begin
    data_nxt = piped;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      data_r <= 10'h000;
    else
      data_r <= data_nxt;
  end

  assign DATA_O = data_r;
  assign DATA_OEN_O = {10{OUTPUT_ENABLE_N_I}};

  ////////////////////////////////////////////////////////////////////////////////
  line_cap_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    LINE_COUNT_O <= 9'd256 && LINE_COUNT_O != 9'd0)
    else $error("line count out of range");
  pixel_cap_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !black_r[PIX_TRIPLE] |-> PIXEL_COUNT_O <= 8'd64)
    else $error("pixel count above 64");
  pixel_triple_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    black_r[PIX_TRIPLE] |-> PIXEL_COUNT_O % 8'd3 == 8'd0 && PIXEL_COUNT_O != 8'd0 && PIXEL_COUNT_O <= 8'd192)
    else $error("triple count wrong");
  gain_range_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    GAIN_CODE_O <= GAIN_MAX)
    else $error("gain code above 383");
  oe_float_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    OUTPUT_ENABLE_N_I |-> DATA_OEN_O == 10'h3ff)
    else $error("outputs driven while disabled");
  test_float_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !test_r[TPIN_HI] |-> TEST_PIN_OEN_O && TEST_PIN_SRC_O == 2'd0)
    else $error("test pins driven");
  cal_start_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    CAL_START_O |-> $past(trig_r) == CAC_ARMED && !$past(BLACK_CAL_TRIGGER_N_I))
    else $error("start without held trigger");
  reg_write_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wr && waddr == ADDR_BLACK_CAL && !soft_rst |=> black_r == $past(wdata))
    else $error("black register not written");
  ref_select_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    INTERNAL_REF_PD_O == EXTERNAL_REFERENCE_O && EXTERNAL_REFERENCE_O == test_r[EXT_REF])
    else $error("reference select mismatch");
  soft_defaults_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    soft_rst |=> black_r == BLACK_CAL_RST && test_r == TEST_BIAS_RST && ctl_r == CONTROL_RST)
    else $error("soft reset left a register changed");
  dac_standby_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wr && waddr == ADDR_CONTROL && !soft_rst |=> USER_DAC1_STANDBY_O == $past(wdata[CTL_DAC1_PD]) &&
    USER_DAC2_STANDBY_O == $past(wdata[CTL_DAC2_PD]))
    else $error("standby bits not taken");
  cal_pulse_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    CAL_START_O |=> !CAL_START_O)
    else $error("start pulse longer than one cycle");
  test_drive_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    test_r[TPIN_HI] |-> !TEST_PIN_OEN_O && TEST_PIN_SRC_O != 2'd0)
    else $error("test pins not driven");
  probe_fine_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    test_r[PROBE_HI:PROBE_LO] != 2'b11 |-> !OFFSET_PROBE_COARSE_O)
    else $error("coarse probe without both bits");
  gain_write_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wr && waddr == ADDR_GAIN && !soft_rst && wdata[8:0] <= GAIN_MAX |=> GAIN_CODE_O == $past(wdata[8:0]))
    else $error("gain code not written");
  src_zero_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    black_r[OSEL_HI:OSEL_LO] == 2'b11 |-> sel_sample == 10'h000)
    else $error("unused source not zero");
endmodule

// File: verilog/cac_out_pipe.sv
`timescale 1ns/1ps
module cac_out_pipe
  import cac_pkg::*;
(
  input wire logic clk_i,           // System clock.
  input wire logic rst_n_i,         // Asynchronous reset, active low.
  input wire logic conv_rise_i,     // Converter clock rising edge pulse.
  input wire logic conv_fall_i,     // Converter clock falling edge pulse.
  input wire logic [9:0] sample_i,  // Sample taken at the rising edge.
  output logic [9:0] data_o         // Sample after 4.5 converter cycles.
);
  // Stage 0 already holds the sample itself, so four further rises need one stage beyond the whole count.
  logic [9:0] stage_r [LATENCY_WHOLE+1];
  logic [9:0] stage_nxt [LATENCY_WHOLE+1];
  logic [9:0] out_r, out_nxt;

  always_comb
  begin
    stage_nxt = stage_r;
    out_nxt = out_r;
    if (conv_rise_i)
    begin
      stage_nxt[0] = sample_i;
      for (int i = 1; i <= LATENCY_WHOLE; i++)
        stage_nxt[i] = stage_r[i-1];
    end
    // The final half cycle: launch on the falling edge after four further rising edges.
    if (conv_fall_i)
      out_nxt = stage_r[LATENCY_WHOLE];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i <= LATENCY_WHOLE; i++)
        stage_r[i] <= 10'h000;
      out_r <= 10'h000;
    end
    else
    begin
      stage_r <= stage_nxt;
      out_r <= out_nxt;
    end
  end

  assign data_o = out_r;
endmodule

// File: verilog/cac_pkg.sv
package cac_pkg;
  // Serial frame layout: two null bits, four address bits, ten data bits.
  localparam int FRAME_BITS = 16;
  localparam int ADDR_MSB = 13;
  localparam int ADDR_LSB = 10;
  localparam int DATA_W = 10;
  // Register addresses carried in the frame.
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_GAIN = 4'h1;
  localparam logic [3:0] ADDR_USER_DAC1 = 4'h2;
  localparam logic [3:0] ADDR_USER_DAC2 = 4'h3;
  localparam logic [3:0] ADDR_BLACK_CAL = 4'h7;
  localparam logic [3:0] ADDR_TEST_BIAS = 4'h8;
  // Reset values.
  localparam logic [9:0] BLACK_CAL_RST = 10'h003;
  localparam logic [9:0] TEST_BIAS_RST = 10'h0c0;
  localparam logic [9:0] CONTROL_RST = 10'h000;
  localparam logic [8:0] GAIN_RST = 9'h000;
  localparam logic [7:0] USER_DAC_RST = 8'h00;
  // Field positions.
  localparam int OSEL_HI = 9;
  localparam int OSEL_LO = 8;
  localparam int LINE_EXP_MSB = 7;
  localparam int LINE_EXP_LSB = 4;
  localparam int PIX_TRIPLE = 3;
  localparam int PIX_EXP_MSB = 2;
  localparam int PIX_EXP_LSB = 0;
  localparam int BIAS_MSB = 9;
  localparam int BIAS_LSB = 6;
  localparam int TPIN_HI = 5;
  localparam int TPIN_LO = 4;
  localparam int EXT_REF = 3;
  localparam int PROBE_HI = 1;
  localparam int PROBE_LO = 0;
  localparam int CTL_DAC1_PD = 8;
  localparam int CTL_DAC2_PD = 7;
  localparam int CTL_SOFT_RESET = 0;
  // Limits.
  localparam logic [3:0] LINE_EXP_MAX = 4'h8;
  localparam logic [2:0] PIX_EXP_MAX = 3'h6;
  localparam logic [8:0] GAIN_MAX = 9'h17f;
  // Whole converter clock cycles of output latency; the half cycle comes from a falling-edge launch.
  localparam int LATENCY_WHOLE = 4;
endpackage

// File: verilog/cac_serial_rx.sv
`timescale 1ns/1ps
module cac_serial_rx
  import cac_pkg::*;
(
  input wire logic clk_i,          // System clock.
  input wire logic rst_n_i,        // Asynchronous reset, active low.
  input wire logic sclk_i,         // Serial clock level.
  input wire logic sdin_i,         // Serial data.
  input wire logic cs_n_i,         // Chip select, active low.
  output logic wr_o,               // One-cycle write strobe.
  output logic [3:0] addr_o,       // Register address.
  output logic [9:0] data_o        // Register data.
);
  logic sclk_r, sclk_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic [15:0] word;

  always_comb
  begin
    sclk_nxt = sclk_i;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    wr_nxt = 1'b0;
    word = {shift_r[14:0], sdin_i};
    if (cs_n_i)
    begin
      // Deasserting select mid-frame drops the partial word.
      cnt_nxt = 5'd0;
    end
    else if (sclk_i && !sclk_r && cnt_r < 5'(FRAME_BITS))
    begin
      shift_nxt = word;
      cnt_nxt = cnt_r + 5'd1;
      wr_nxt = (cnt_r == 5'(FRAME_BITS - 1));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sclk_r <= 1'b0;
      shift_r <= 16'h0000;
      cnt_r <= 5'd0;
      wr_r <= 1'b0;
    end
    else
    begin
      sclk_r <= sclk_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
    end
  end

  assign wr_o = wr_r;
  assign addr_o = shift_r[ADDR_MSB:ADDR_LSB];
  assign data_o = shift_r[DATA_W-1:0];

  full_frame_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_r |-> $past(cnt_r) == 5'(FRAME_BITS - 1) && !$past(cs_n_i))
    else $error("write without full frame");
endmodule
